// *** include/pmrc_map.svh ***
`ifndef PMRC_MAP_SVH
`define PMRC_MAP_SVH
`define PMRC_REGCTL_ADDR 8'hC9
`define PMRC_PWRCTL_ADDR 8'h87
`define PMRC_OSCCTL_ADDR 8'hB2
`define PMRC_REGCTL_RST 8'h00
`define PMRC_PWRCTL_RST 8'h00
`define PMRC_REGCTL_WMASK 8'hBF
`define PMRC_UNMAPPED_RD 8'h00
`define PMRC_BIT_PRIM_DIS 7
`define PMRC_BIT_WAKE_LVL 6
`define PMRC_BIT_PRIM_LP 4
`define PMRC_BIT_STOP_CFG 3
`define PMRC_BIT_CORE_LP 1
`define PMRC_BIT_STOP_SEL 1
`define PMRC_BIT_IDLE_SEL 0
`define PMRC_BIT_SUSPEND 5
`define PMRC_GPF_LSB 2
`endif

// *** include/pmrc_pkg.sv ***
package pmrc_pkg;
  typedef logic [7:0] pmrc_byte_t;
  typedef enum logic [1:0] {
    PMRC_RUN = 2'h0,
    PMRC_IDLE = 2'h1,
    PMRC_SUSP = 2'h2,
    PMRC_STOP = 2'h3
  } pmrc_mode_t;
endpackage

// *** include/pmrc_sfr_if.sv ***
`timescale 1ns/1ps
interface pmrc_sfr_if;
  logic idleReq;
  logic stopReq;
  logic suspendReq;
  logic primaryRegDisable;
  logic primaryRegLowpower;
  logic stopRegConfig;
  logic coreRegLowpower;
  logic wakeLevel;
  logic suspendActive;
  modport sfr (
    output idleReq, stopReq, suspendReq, primaryRegDisable, primaryRegLowpower,
    output stopRegConfig, coreRegLowpower,
    input wakeLevel, suspendActive
  );
  modport ctl (
    input idleReq, stopReq, suspendReq, primaryRegDisable, primaryRegLowpower,
    input stopRegConfig, coreRegLowpower,
    output wakeLevel, suspendActive
  );
endinterface

// *** logic/pmrc_sfr.sv ***
`timescale 1ns/1ps
`include "pmrc_map.svh"
module pmrc_sfr (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire pmrc_pkg::pmrc_byte_t sfrWrData,
  output pmrc_pkg::pmrc_byte_t sfrRdData_q,
  pmrc_sfr_if.sfr regs
);
  import pmrc_pkg::*;

  pmrc_byte_t regCtl_q;
  logic [5:0] gpFlags_q;
  logic wrReg, wrPwr, wrOsc;

  assign wrReg = sfrWrEn && sfrAddr == `PMRC_REGCTL_ADDR;
  assign wrPwr = sfrWrEn && sfrAddr == `PMRC_PWRCTL_ADDR;
  assign wrOsc = sfrWrEn && sfrAddr == `PMRC_OSCCTL_ADDR;

  // the wake level bit is never stored, it is a live view of the pin
  always_ff @(posedge clock) begin
    if (rst) begin
      regCtl_q <= `PMRC_REGCTL_RST;
    end else if (wrReg) begin
      regCtl_q <= sfrWrData & `PMRC_REGCTL_WMASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gpFlags_q <= 6'h00;
    end else if (wrPwr) begin
      gpFlags_q <= sfrWrData[7:`PMRC_GPF_LSB];
    end
  end

  assign regs.idleReq = wrPwr && sfrWrData[`PMRC_BIT_IDLE_SEL];
  assign regs.stopReq = wrPwr && sfrWrData[`PMRC_BIT_STOP_SEL];
  assign regs.suspendReq = wrOsc && sfrWrData[`PMRC_BIT_SUSPEND];
  assign regs.primaryRegDisable = regCtl_q[`PMRC_BIT_PRIM_DIS];
  assign regs.primaryRegLowpower = regCtl_q[`PMRC_BIT_PRIM_LP];
  assign regs.stopRegConfig = regCtl_q[`PMRC_BIT_STOP_CFG];
  assign regs.coreRegLowpower = regCtl_q[`PMRC_BIT_CORE_LP];

  always_ff @(posedge clock) begin
    if (rst) begin
      sfrRdData_q <= `PMRC_UNMAPPED_RD;
    end else if (sfrRdEn) begin
      unique case (sfrAddr)
        `PMRC_REGCTL_ADDR: begin
          sfrRdData_q <= regCtl_q;
          sfrRdData_q[`PMRC_BIT_WAKE_LVL] <= regs.wakeLevel;
        end
        `PMRC_PWRCTL_ADDR: sfrRdData_q <= {gpFlags_q, 2'h0};
        `PMRC_OSCCTL_ADDR: sfrRdData_q <= {2'h0, regs.suspendActive, 5'h00};
        default: sfrRdData_q <= `PMRC_UNMAPPED_RD;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  wake_read_a: assert property (
    sfrRdEn && sfrAddr == `PMRC_REGCTL_ADDR |=> sfrRdData_q[6] == $past(regs.wakeLevel))
    else $error("wake level bit wrong on read");
  pwr_zero_a: assert property (
    sfrRdEn && sfrAddr == `PMRC_PWRCTL_ADDR |=> sfrRdData_q[1:0] == 2'h0)
    else $error("mode select bits did not read as zero");
  reg_reset_a: assert property (
    $past(rst) |-> regCtl_q == `PMRC_REGCTL_RST)
    else $error("regulator control not cleared by reset");
endmodule

// *** logic/pmrc_top.sv ***
`timescale 1ns/1ps
`include "pmrc_map.svh"
// How it works
// - bit 7 set disables primary regulator
// - bit 6 reads live wake pin level
// - bit 4 selects primary regulator low power
// - bit 3 shuts core regulator in stop
// - bit 1 selects core regulator low power
// - register at 0xC9, resets to zero
// - idle bit halts CPU after instruction
// - enabled interrupt ends idle, resumes CPU
// - reset ends idle or suspend, restarts
// - watchdog reset eventually ends idle
// - stop bit halts oscillator, CPU, peripherals
// - only reset ends stop mode
// - missing clock reset ends stop, unless bit 3 set
// - suspend bit halts only fast oscillator
// - wake pin edge or reset ends suspend
// - resume after suspend, service wake interrupt (resume pulse only if CPU ran from fast oscillator)
// - wake interrupt on both edges, no flag
// - stop bit 1, idle bit 0, read zero
module pmrc_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire pmrc_pkg::pmrc_byte_t sfrWrData,
  output pmrc_pkg::pmrc_byte_t sfrRdData_q,
  input wire logic instrDone,
  input wire logic irqPending,
  input wire logic wakePin,
  input wire logic wakeIrqEn,
  input wire logic hfOscSelected,
  input wire logic rstPinReq,
  input wire logic watchdogRstReq,
  input wire logic missingClkRstReq,
  input wire logic otherRstReq,
  output pmrc_pkg::pmrc_mode_t powerMode_q,
  output logic cpuHalt_q,
  output logic cpuResume_q,
  output logic intOscStop_q,
  output logic hfOscStop_q,
  output logic periphClkStop_q,
  output logic primaryRegDisable_q,
  output logic primaryRegLowpower_q,
  output logic coreRegLowpower_q,
  output logic coreRegShutdown_q,
  output logic wakeIrq_q,
  output logic deviceReset_q
);
  import pmrc_pkg::*;

  pmrc_mode_t mode_q;
  pmrc_mode_t mode_d;
  logic localRst;
  logic idleArm_q;
  logic stopArm_q;
  logic suspArm_q;
  logic idleNow;
  logic stopNow;
  logic suspNow;
  logic wakePrev_q;
  logic wakePrimed_q;
  logic wakeEdge;
  logic rstAccept;
  logic anyInternalRst;

  pmrc_sfr_if sfrBus ();

  function automatic logic cpuStalled(input pmrc_mode_t m);
    return m == PMRC_IDLE || m == PMRC_STOP;
  endfunction

  function automatic logic fastOscOff(input pmrc_mode_t m);
    return m == PMRC_STOP || m == PMRC_SUSP;
  endfunction

  // a device reset clears every mode, arm flag and register except deviceReset_q itself, same as power-up
  assign localRst = sys_rst || deviceReset_q;

  pmrc_sfr u_sfr (
    .clock(clock),
    .rst(localRst),
    .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn),
    .sfrWrData(sfrWrData),
    .sfrRdData_q(sfrRdData_q),
    .regs(sfrBus.sfr)
  );

  assign sfrBus.wakeLevel = wakePin;
  assign sfrBus.suspendActive = mode_q == PMRC_SUSP;

  // reset acceptance
  assign anyInternalRst = watchdogRstReq || missingClkRstReq || otherRstReq;
  // with the core regulator shut down only the reset pin still reaches us
  assign rstAccept = rstPinReq ||
    (anyInternalRst && !(mode_q == PMRC_STOP && sfrBus.stopRegConfig));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      deviceReset_q <= 1'b0;
    end else begin
      deviceReset_q <= rstAccept;
    end
  end

  // wake pin edges
  // primed flag stops a pin that is high at reset release looking like an edge
  always_ff @(posedge clock) begin
    if (localRst) begin
      wakePrev_q <= 1'b0;
      wakePrimed_q <= 1'b0;
    end else begin
      wakePrev_q <= wakePin;
      wakePrimed_q <= 1'b1;
    end
  end

  assign wakeEdge = wakePrimed_q && (wakePin != wakePrev_q);

  always_ff @(posedge clock) begin
    if (localRst) begin
      wakeIrq_q <= 1'b0;
    end else begin
      // interrupts are dead in stop; no pending flag is kept
      wakeIrq_q <= wakeIrqEn && wakeEdge && mode_q != PMRC_STOP;
    end
  end

  // mode requests wait for the writing instruction to finish
  assign idleNow = idleArm_q || sfrBus.idleReq;
  assign stopNow = stopArm_q || sfrBus.stopReq;
  assign suspNow = suspArm_q || sfrBus.suspendReq;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      PMRC_RUN: begin
        if (instrDone) begin
          if (stopNow) begin
            mode_d = PMRC_STOP;
          end else if (idleNow) begin
            mode_d = PMRC_IDLE;
          end else if (suspNow) begin
            mode_d = PMRC_SUSP;
          end
        end
      end
      PMRC_IDLE: begin
        if (irqPending) begin
          mode_d = PMRC_RUN;
        end
      end
      PMRC_SUSP: begin
        if (wakeEdge) begin
          mode_d = PMRC_RUN;
        end
      end
      PMRC_STOP: begin
        mode_d = PMRC_STOP;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (localRst) begin
      mode_q <= PMRC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // arm flags: a request in the same cycle as the entry does not set the flag
  // stop outranks idle, idle outranks suspend; a same-cycle loser is not armed
  always_ff @(posedge clock) begin
    if (localRst) begin
      idleArm_q <= 1'b0;
    end else if (sfrBus.idleReq && !(mode_q == PMRC_RUN && instrDone)) begin
      idleArm_q <= 1'b1;
    end else if (mode_q == PMRC_RUN && mode_d == PMRC_IDLE) begin
      idleArm_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (localRst) begin
      stopArm_q <= 1'b0;
    end else if (sfrBus.stopReq && !(mode_q == PMRC_RUN && instrDone)) begin
      stopArm_q <= 1'b1;
    end else if (mode_q == PMRC_RUN && mode_d == PMRC_STOP) begin
      stopArm_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (localRst) begin
      suspArm_q <= 1'b0;
    end else if (sfrBus.suspendReq && !(mode_q == PMRC_RUN && instrDone)) begin
      suspArm_q <= 1'b1;
    end else if (mode_q == PMRC_RUN && mode_d == PMRC_SUSP) begin
      suspArm_q <= 1'b0;
    end
  end

  // clock and CPU controls
  always_ff @(posedge clock) begin
    if (localRst) begin
      powerMode_q <= PMRC_RUN;
      cpuHalt_q <= 1'b0;
      intOscStop_q <= 1'b0;
      hfOscStop_q <= 1'b0;
      periphClkStop_q <= 1'b0;
    end else begin
      powerMode_q <= mode_d;
      cpuHalt_q <= cpuStalled(mode_d);
      intOscStop_q <= mode_d == PMRC_STOP;
      hfOscStop_q <= fastOscOff(mode_d);
      periphClkStop_q <= mode_d == PMRC_STOP;
    end
  end

  // on a suspend wake the CPU only stalled if it ran from the fast oscillator
  always_ff @(posedge clock) begin
    if (localRst) begin
      cpuResume_q <= 1'b0;
    end else begin
      cpuResume_q <= (mode_q == PMRC_IDLE && mode_d == PMRC_RUN) ||
        (mode_q == PMRC_SUSP && mode_d == PMRC_RUN && hfOscSelected);
    end
  end

  // regulator controls
  // a software slip on core low power with the primary off is passed through as is
  always_ff @(posedge clock) begin
    if (localRst) begin
      primaryRegDisable_q <= 1'b0;
      primaryRegLowpower_q <= 1'b0;
      coreRegLowpower_q <= 1'b0;
      coreRegShutdown_q <= 1'b0;
    end else begin
      primaryRegDisable_q <= sfrBus.primaryRegDisable;
      primaryRegLowpower_q <= sfrBus.primaryRegLowpower;
      coreRegLowpower_q <= sfrBus.coreRegLowpower;
      coreRegShutdown_q <= mode_d == PMRC_STOP && sfrBus.stopRegConfig;
    end
  end

  // checks on the reset path itself only drop out on sys_rst, since they watch deviceReset_q
  default clocking cb @(posedge clock); endclocking
  default disable iff (localRst);

  idle_entry_a: assert property (
    mode_q == PMRC_RUN && instrDone && idleNow && !stopNow
    |=> mode_q == PMRC_IDLE && cpuHalt_q && !intOscStop_q)
    else $error("idle not entered after writing instruction");

  idle_exit_a: assert property (
    mode_q == PMRC_IDLE && irqPending |=> mode_q == PMRC_RUN && cpuResume_q && !cpuHalt_q)
    else $error("interrupt did not end idle");

  stop_entry_a: assert property (
    mode_q == PMRC_RUN && instrDone && stopNow
    |=> cpuHalt_q && intOscStop_q && periphClkStop_q && hfOscStop_q)
    else $error("stop not entered with clocks halted");

  stop_hold_a: assert property (
    mode_q == PMRC_STOP && !rstAccept |=> mode_q == PMRC_STOP)
    else $error("stop left without reset");

  stop_shield_a: assert property (@(posedge clock) disable iff (sys_rst)
    mode_q == PMRC_STOP && sfrBus.stopRegConfig && !rstPinReq |=> !deviceReset_q)
    else $error("reset accepted while core regulator shut down");

  rst_ends_a: assert property (@(posedge clock) disable iff (sys_rst)
    rstAccept && mode_q != PMRC_RUN |=> deviceReset_q ##1 mode_q == PMRC_RUN)
    else $error("reset did not end power mode");

  susp_wake_a: assert property (
    mode_q == PMRC_SUSP && wakeEdge |=> mode_q == PMRC_RUN && !hfOscStop_q)
    else $error("wake edge did not end suspend");

  wake_irq_a: assert property (
    wakeIrqEn && wakeEdge && mode_q != PMRC_STOP |=> wakeIrq_q ##1 (!wakeIrq_q || $past(wakeEdge)))
    else $error("wake interrupt missing on edge");

  shut_stop_a: assert property (
    coreRegShutdown_q |-> powerMode_q == PMRC_STOP && cpuHalt_q)
    else $error("core regulator shut outside stop");

  core_lp_a: assert property (
    $rose(sfrBus.coreRegLowpower) |=> coreRegLowpower_q)
    else $error("core low power not applied");

  reg_copy_a: assert property (
    1'b1 |=> primaryRegDisable_q == $past(sfrBus.primaryRegDisable) &&
    primaryRegLowpower_q == $past(sfrBus.primaryRegLowpower))
    else $error("regulator control bits not passed on");

  susp_entry_a: assert property (
    mode_q == PMRC_RUN && instrDone && suspNow && !stopNow && !idleNow
    |=> mode_q == PMRC_SUSP && hfOscStop_q && !cpuHalt_q && !intOscStop_q && !periphClkStop_q)
    else $error("suspend stopped more than the fast oscillator");

  susp_resume_a: assert property (
    mode_q == PMRC_SUSP && wakeEdge |=> cpuResume_q == $past(hfOscSelected))
    else $error("suspend wake resume pulse wrong");

  stop_mcd_a: assert property (@(posedge clock) disable iff (sys_rst)
    mode_q == PMRC_STOP && !sfrBus.stopRegConfig && missingClkRstReq |=> deviceReset_q)
    else $error("missing clock reset did not end stop");

  idle_wdog_a: assert property (@(posedge clock) disable iff (sys_rst)
    mode_q == PMRC_IDLE && watchdogRstReq |=> deviceReset_q)
    else $error("watchdog reset did not end idle");

  stop_quiet_a: assert property (
    mode_q == PMRC_STOP |=> !wakeIrq_q)
    else $error("wake interrupt raised in stop");

  idle_keep_a: assert property (
    mode_q == PMRC_IDLE && !irqPending |=> mode_q == PMRC_IDLE && cpuHalt_q)
    else $error("idle left without interrupt");

  stop_cfg_a: assert property (
    mode_q == PMRC_RUN && instrDone && stopNow
    |=> coreRegShutdown_q == $past(sfrBus.stopRegConfig))
    else $error("core regulator shutdown does not follow stop config");

  rst_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(deviceReset_q) && !deviceReset_q
    |-> mode_q == PMRC_RUN && !cpuHalt_q && !hfOscStop_q && !coreRegShutdown_q)
    else $error("device reset left a power mode behind");

  // main scenarios: each mode entered and left by its own wake source
  idle_wake_c: cover property (mode_q == PMRC_IDLE ##[1:20] cpuResume_q);
  susp_wake_c: cover property (mode_q == PMRC_SUSP ##[1:20] mode_q == PMRC_RUN);
  stop_rst_c: cover property (@(posedge clock) disable iff (sys_rst)
    mode_q == PMRC_STOP ##[1:20] deviceReset_q);
  shut_pin_c: cover property (@(posedge clock) disable iff (sys_rst)
    coreRegShutdown_q && rstPinReq ##1 deviceReset_q);
  susp_cold_c: cover property (mode_q == PMRC_SUSP && wakeEdge && !hfOscSelected);
endmodule

// *** verif/pmrc_top_tb.sv ***
`timescale 1ns/1ps
module pmrc_top_tb;
  import pmrc_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  pmrc_byte_t sfrWrData = 8'h00;
  pmrc_byte_t sfrRdData_q;
  logic instrDone = 1'b0;
  logic irqPending = 1'b0;
  logic wakePin = 1'b0;
  logic wakeIrqEn = 1'b1;
  logic hfOscSelected = 1'b1;
  logic rstPinReq = 1'b0;
  logic watchdogRstReq = 1'b0;
  logic missingClkRstReq = 1'b0;
  logic otherRstReq = 1'b0;
  pmrc_mode_t powerMode_q;
  logic cpuHalt_q, cpuResume_q, intOscStop_q, hfOscStop_q, periphClkStop_q;
  logic primaryRegDisable_q, primaryRegLowpower_q, coreRegLowpower_q, coreRegShutdown_q;
  logic wakeIrq_q, deviceReset_q;
  logic rstSeen = 1'b0;
  pmrc_byte_t nWake = 8'h00, nRes = 8'h00, nRst = 8'h00;
  pmrc_byte_t eWake = 8'h00, eRes = 8'h00, eRst = 8'h00;
  int err_total = 0;
  int n_checks = 0;

  pmrc_top dut (
    .clock(clock), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData_q(sfrRdData_q),
    .instrDone(instrDone), .irqPending(irqPending), .wakePin(wakePin),
    .wakeIrqEn(wakeIrqEn), .hfOscSelected(hfOscSelected), .rstPinReq(rstPinReq),
    .watchdogRstReq(watchdogRstReq), .missingClkRstReq(missingClkRstReq),
    .otherRstReq(otherRstReq), .powerMode_q(powerMode_q), .cpuHalt_q(cpuHalt_q),
    .cpuResume_q(cpuResume_q), .intOscStop_q(intOscStop_q), .hfOscStop_q(hfOscStop_q),
    .periphClkStop_q(periphClkStop_q), .primaryRegDisable_q(primaryRegDisable_q),
    .primaryRegLowpower_q(primaryRegLowpower_q), .coreRegLowpower_q(coreRegLowpower_q),
    .coreRegShutdown_q(coreRegShutdown_q), .wakeIrq_q(wakeIrq_q),
    .deviceReset_q(deviceReset_q)
  );

  initial begin
    forever #10 clock = ~clock;
  end

  // pulses are counted rather than caught, so a stretched wake or resume pulse shows as a wrong count; resets count by rising edge
  always @(posedge clock) begin
    rstSeen <= deviceReset_q;
    if (wakeIrq_q === 1'b1) nWake <= nWake + 8'h01;
    if (cpuResume_q === 1'b1) nRes <= nRes + 8'h01;
    if (deviceReset_q === 1'b1 && rstSeen !== 1'b1) nRst <= nRst + 8'h01;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input pmrc_byte_t exp, input pmrc_byte_t got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // flags: cpuHalt, intOscStop, hfOscStop, periphClkStop, coreRegShutdown
  task automatic st(input pmrc_mode_t m, input logic [4:0] f);
    chk("power mode", {6'h00, m}, {6'h00, powerMode_q});
    chk("mode outputs", {3'h0, f}, {3'h0, cpuHalt_q, intOscStop_q, hfOscStop_q,
        periphClkStop_q, coreRegShutdown_q});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input pmrc_byte_t d, input logic done);
    @(negedge clock);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    instrDone = done;
    @(negedge clock);
    sfrWrEn = 1'b0;
    instrDone = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input pmrc_byte_t exp);
    @(negedge clock);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clock);
    sfrRdEn = 1'b0;
    chk($sformatf("read of %h", a), exp, sfrRdData_q);
  endtask

  task automatic flip;
    step(1);
    wakePin = ~wakePin;
    step(3);
  endtask

  task automatic endt(input string nm);
    chk("wake irq count", eWake, nWake);
    chk("resume count", eRes, nRes);
    chk("reset count", eRst, nRst);
    $display("test %s done, mismatches %0d", nm, err_total);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    report_and_stop();
  end

  initial begin
    step(3);
    sys_rst = 1'b0;
    rdc(8'hC9, 8'h00);
    rdc(8'h87, 8'h00);
    rdc(8'h55, 8'h00);
    wr(8'hC9, 8'h90, 1'b0);
    step(1);
    chk("regulator bits", 8'h06, {5'h00, primaryRegDisable_q, primaryRegLowpower_q,
        coreRegLowpower_q});
    wr(8'hC9, 8'h52, 1'b0);
    step(1);
    chk("regulator bits", 8'h03, {5'h00, primaryRegDisable_q, primaryRegLowpower_q,
        coreRegLowpower_q});
    rdc(8'hC9, 8'h12);
    flip();
    rdc(8'hC9, 8'h52);
    flip();
    rdc(8'hC9, 8'h12);
    eWake = eWake + 8'h02;
    endt("register");
    wr(8'h87, 8'hFD, 1'b1);
    step(2);
    st(PMRC_IDLE, 5'b10000);
    rdc(8'h87, 8'hFC);
    rdc(8'hC9, 8'h12);
    step(1);
    irqPending = 1'b1;
    step(1);
    irqPending = 1'b0;
    step(2);
    st(PMRC_RUN, 5'b00000);
    eRes = eRes + 8'h01;
    wr(8'h87, 8'h01, 1'b1);
    step(2);
    st(PMRC_IDLE, 5'b10000);
    watchdogRstReq = 1'b1;
    step(1);
    watchdogRstReq = 1'b0;
    step(3);
    st(PMRC_RUN, 5'b00000);
    eRst = eRst + 8'h01;
    rdc(8'h87, 8'h00);
    rdc(8'hC9, 8'h00);
    endt("idle");
    wr(8'hC9, 8'h00, 1'b0);
    wr(8'h87, 8'h02, 1'b1);
    step(2);
    st(PMRC_STOP, 5'b11110);
    irqPending = 1'b1;
    step(1);
    irqPending = 1'b0;
    flip();
    st(PMRC_STOP, 5'b11110);
    missingClkRstReq = 1'b1;
    step(1);
    missingClkRstReq = 1'b0;
    step(3);
    st(PMRC_RUN, 5'b00000);
    eRst = eRst + 8'h01;
    endt("stop");
    // the shut-down core only answers the reset pin, so the other sources must be ignored
    wr(8'hC9, 8'h08, 1'b0);
    wr(8'h87, 8'h02, 1'b1);
    step(2);
    st(PMRC_STOP, 5'b11111);
    watchdogRstReq = 1'b1;
    missingClkRstReq = 1'b1;
    otherRstReq = 1'b1;
    step(1);
    watchdogRstReq = 1'b0;
    missingClkRstReq = 1'b0;
    otherRstReq = 1'b0;
    step(3);
    st(PMRC_STOP, 5'b11111);
    rstPinReq = 1'b1;
    step(1);
    rstPinReq = 1'b0;
    step(3);
    st(PMRC_RUN, 5'b00000);
    eRst = eRst + 8'h01;
    endt("stop shutdown");
    // core low power needs a settling gap before the fast oscillator may be suspended
    wr(8'hC9, 8'h12, 1'b0);
    step(12);
    wr(8'hB2, 8'h20, 1'b1);
    step(2);
    st(PMRC_SUSP, 5'b00100);
    chk("regulator bits", 8'h03, {5'h00, primaryRegDisable_q, primaryRegLowpower_q,
        coreRegLowpower_q});
    rdc(8'hB2, 8'h20);
    flip();
    st(PMRC_RUN, 5'b00000);
    eRes = eRes + 8'h01;
    eWake = eWake + 8'h01;
    rdc(8'hB2, 8'h00);
    hfOscSelected = 1'b0;
    wakeIrqEn = 1'b0;
    wr(8'hB2, 8'h20, 1'b1);
    step(2);
    st(PMRC_SUSP, 5'b00100);
    flip();
    st(PMRC_RUN, 5'b00000);
    wr(8'hB2, 8'h20, 1'b1);
    step(2);
    otherRstReq = 1'b1;
    step(1);
    otherRstReq = 1'b0;
    step(3);
    st(PMRC_RUN, 5'b00000);
    eRst = eRst + 8'h01;
    endt("suspend");
    report_and_stop();
  end
endmodule
